// file: src/sprc_pkg.sv
package sprc_pkg;

    // register byte addresses
    localparam int          AXI_AW        = 32;
    localparam logic [31:0] REG_REVISION  = 32'h1000_000C;
    localparam logic [31:0] REG_CHIP_ID   = 32'h1000_0010;
    localparam logic [31:0] REG_PLL_CTRL  = 32'h1000_0014;
    localparam logic [31:0] REG_RST_CFG   = 32'h1000_0018;
    localparam logic [31:0] REG_RST_STAT  = 32'h1000_001C;

    // field positions
    localparam int SEC_STBY_POS   = 5;
    localparam int FIRST_STBY_POS = 4;
    localparam int SEC_BYP_POS    = 1;
    localparam int FIRST_BYP_POS  = 0;
    localparam int MAJOR_LSB      = 8;
    localparam int MINOR_LSB      = 0;
    localparam int VARIANT_POS    = 0;
    localparam int ST_POR_OUT_POS = 0;
    localparam int ST_MAN_OUT_POS = 1;
    localparam int ST_POR_IN_POS  = 2;
    localparam int ST_MAN_IN_POS  = 3;

    // reset values
    localparam logic [1:0] PLL_STBY_RST = 2'h0;
    localparam logic [1:0] PLL_BYP_RST  = 2'h0;
    localparam logic       VARIANT_RST  = 1'b0;

    // bus answers
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // timing
    localparam int MCLK_NS     = 40;
    localparam int LEAD_NS     = 80;
    localparam int LAG_NS      = 80;
    localparam int LEAD_CYC    = (LEAD_NS + MCLK_NS - 1) / MCLK_NS;
    localparam int LAG_CYC     = (LAG_NS + MCLK_NS - 1) / MCLK_NS;
    localparam int SEQ_W       = $clog2(LEAD_CYC + LAG_CYC + 1);
    localparam int PULSE_MS    = 10;
    localparam int AFE_KHZ_DEF = 1000;

    typedef enum logic [1:0] {
        MS_IDLE,
        MS_LEAD,
        MS_HOLD,
        MS_LAG
    } sprc_man_st_t;

endpackage

// file: src/sprc_pulse_timer.sv
`timescale 1ns/100ps
module sprc_pulse_timer
    import sprc_pkg::*;
#(
    parameter int unsigned TICKS = 10000
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic ce,
    // control
    input  wire logic hold,
    input  wire logic tick,
    output logic      done
);
    localparam int CW = $clog2(TICKS + 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
    } sprc_tmr_st_t;

    sprc_tmr_st_t st_ff;
    sprc_tmr_st_t nxt_st;

    assign done = (st_ff.cnt == CW'(TICKS));

    always_comb begin
        nxt_st = st_ff;
        if (hold) begin
            nxt_st.cnt = '0;
        end else if (tick && !done) begin
            nxt_st.cnt = st_ff.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end
endmodule

// file: src/sprc_axil_slave.sv
`timescale 1ns/100ps
module sprc_axil_slave
    import sprc_pkg::*;
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              ce,
    // write channels
    input  wire logic [AXI_AW-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    // read channels
    input  wire logic [AXI_AW-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    // register file side
    output logic                   wr_en,
    output logic [AXI_AW-1:0]      wr_addr,
    output logic [31:0]            wr_data,
    output logic [3:0]             wr_strb,
    input  wire logic              wr_ok,
    output logic                   rd_req,
    output logic [AXI_AW-1:0]      rd_addr,
    input  wire logic [31:0]       rd_data,
    input  wire logic              rd_ok
);
    typedef struct packed {
        logic              aw_full;
        logic              w_full;
        logic [AXI_AW-1:0] addr;
        logic [31:0]       data;
        logic [3:0]        strb;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [1:0]        rresp;
        logic [31:0]       rdata;
    } sprc_axil_st_t;

    sprc_axil_st_t st_ff;
    sprc_axil_st_t nxt_st;

    assign awready = ce & ~st_ff.aw_full;
    assign wready  = ce & ~st_ff.w_full;
    assign arready = ce & ~st_ff.rvalid;
    assign wr_en   = ce & st_ff.aw_full & st_ff.w_full & ~st_ff.bvalid;
    assign wr_addr = st_ff.addr;
    assign wr_data = st_ff.data;
    assign wr_strb = st_ff.strb;
    assign rd_req  = arvalid & arready;
    assign rd_addr = araddr;
    assign bvalid  = st_ff.bvalid;
    assign bresp   = st_ff.bresp;
    assign rvalid  = st_ff.rvalid;
    assign rresp   = st_ff.rresp;
    assign rdata   = st_ff.rdata;

    always_comb begin
        nxt_st = st_ff;
        if (awvalid && awready) begin
            nxt_st.aw_full = 1'b1;
            nxt_st.addr    = awaddr;
        end
        if (wvalid && wready) begin
            nxt_st.w_full = 1'b1;
            nxt_st.data   = wdata;
            nxt_st.strb   = wstrb;
        end
        if (st_ff.bvalid && bready) begin
            nxt_st.bvalid = 1'b0;
        end
        // address and data both held: commit, then answer
        if (wr_en) begin
            nxt_st.aw_full = 1'b0;
            nxt_st.w_full  = 1'b0;
            nxt_st.bvalid  = 1'b1;
            nxt_st.bresp   = wr_ok ? RESP_OKAY : RESP_SLVERR;
        end
        if (st_ff.rvalid && rready) begin
            nxt_st.rvalid = 1'b0;
        end
        if (rd_req) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rdata  = rd_data;
            nxt_st.rresp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end
endmodule

// file: src/sprc_top.sv
// Summary of operation
// - Bits 5 and 4 of the PLL control register put the second and first PLL in standby; both reset to 0.
// - Bits 1 and 0 bypass the second and first PLL, input straight to output; both reset to 0.
// - A read-only revision register holds the major number in bits 15:8, minor in its low byte.
// - A read-only chip identity register returns a fixed code and ignores writes.
// - An asserted power-on reset input drives the power-on reset output with a 10 ms pulse period.
// - An asserted manual reset input drives the manual reset output; second CPU variant pulse is 10 ms.
// - First CPU variant uses 80 ns lead and lag around the combined outputs and a 10 ms hold.
// - The manual reset input is only forwarded and never reinitialises a register of this block.
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/100ps
module sprc_top
    import sprc_pkg::*;
#(
    parameter int          AFE_CLK_KHZ = AFE_KHZ_DEF,
    parameter int unsigned POR_TICKS   = PULSE_MS * AFE_CLK_KHZ,
    parameter int unsigned MAN_TICKS   = PULSE_MS * AFE_CLK_KHZ,
    parameter logic [7:0]  REV_MAJOR   = 8'h03,     // arbitrary
    parameter logic [7:0]  REV_MINOR   = 8'h02,     // arbitrary
    parameter logic [15:0] CHIP_ID     = 16'h5A3C   // arbitrary
) (
    // clock, reset, enable
    input  wire logic              MCLK,
    input  wire logic              RESET_N,
    input  wire logic              CE,
    // axi4-lite write
    input  wire logic [AXI_AW-1:0] AWADDR,
    input  wire logic              AWVALID,
    output logic                   AWREADY,
    input  wire logic [31:0]       WDATA,
    input  wire logic [3:0]        WSTRB,
    input  wire logic              WVALID,
    output logic                   WREADY,
    output logic [1:0]             BRESP,
    output logic                   BVALID,
    input  wire logic              BREADY,
    // axi4-lite read
    input  wire logic [AXI_AW-1:0] ARADDR,
    input  wire logic              ARVALID,
    output logic                   ARREADY,
    output logic [31:0]            RDATA,
    output logic [1:0]             RRESP,
    output logic                   RVALID,
    input  wire logic              RREADY,
    // reset pins
    input  wire logic              POWER_ON_RESET_IN_N,
    input  wire logic              MANUAL_RESET_IN_N,
    input  wire logic              FRONT_END_CLOCK_IN,
    output logic                   POWER_ON_RESET_OUT_N,
    output logic                   MANUAL_RESET_OUT_N,
    // pll controls
    output logic                   FIRST_PLL_STANDBY,
    output logic                   SECOND_PLL_STANDBY,
    output logic                   FIRST_PLL_BYPASS,
    output logic                   SECOND_PLL_BYPASS
);
    // sync bit order: 0 power-on in, 1 manual in, 2 front-end clock
    typedef struct packed {
        logic [2:0]   sy1;
        logic [2:0]   sy2;
        logic         afe_prev;
        logic [1:0]   pll_sb;
        logic [1:0]   pll_bp;
        logic         variant_sel;
        sprc_man_st_t man_st;
        logic         man_var;
        logic [SEQ_W-1:0] seq_cnt;
        logic         por_out_n;
        logic         man_out_n;
    } sprc_top_st_t;

    sprc_top_st_t      st_ff;
    sprc_top_st_t      nxt_st;
    logic              wr_en;
    logic [AXI_AW-1:0] wr_addr;
    logic [31:0]       wr_data;
    logic [3:0]        wr_strb;
    logic              wr_ok;
    logic              rd_req;
    logic [AXI_AW-1:0] rd_addr;
    logic [31:0]       rd_data;
    logic              rd_ok;
    logic              afe_tick;
    logic              por_done;
    logic              man_done;

    sprc_axil_slave u_bus (
        .clk     (MCLK),
        .rst_n   (RESET_N),
        .ce      (CE),
        .awaddr  (AWADDR),
        .awvalid (AWVALID),
        .awready (AWREADY),
        .wdata   (WDATA),
        .wstrb   (WSTRB),
        .wvalid  (WVALID),
        .wready  (WREADY),
        .bresp   (BRESP),
        .bvalid  (BVALID),
        .bready  (BREADY),
        .araddr  (ARADDR),
        .arvalid (ARVALID),
        .arready (ARREADY),
        .rdata   (RDATA),
        .rresp   (RRESP),
        .rvalid  (RVALID),
        .rready  (RREADY),
        .wr_en   (wr_en),
        .wr_addr (wr_addr),
        .wr_data (wr_data),
        .wr_strb (wr_strb),
        .wr_ok   (wr_ok),
        .rd_req  (rd_req),
        .rd_addr (rd_addr),
        .rd_data (rd_data),
        .rd_ok   (rd_ok)
    );

    // periods counted in rising front-end clock edges
    assign afe_tick = st_ff.sy2[2] & ~st_ff.afe_prev;

    sprc_pulse_timer #(.TICKS(POR_TICKS)) u_por_tmr (
        .clk   (MCLK),
        .rst_n (RESET_N),
        .ce    (CE),
        .hold  (~st_ff.sy2[0]),
        .tick  (afe_tick),
        .done  (por_done)
    );

    sprc_pulse_timer #(.TICKS(MAN_TICKS)) u_man_tmr (
        .clk   (MCLK),
        .rst_n (RESET_N),
        .ce    (CE),
        .hold  ((st_ff.man_st != MS_HOLD) | ~st_ff.sy2[1]),
        .tick  (afe_tick),
        .done  (man_done)
    );

    assign wr_ok = (wr_addr == REG_REVISION) || (wr_addr == REG_CHIP_ID) ||
                   (wr_addr == REG_PLL_CTRL) || (wr_addr == REG_RST_CFG) ||
                   (wr_addr == REG_RST_STAT);

    always_comb begin
        rd_data = '0;
        rd_ok   = 1'b1;
        case (rd_addr)
            REG_REVISION: begin
                rd_data[MAJOR_LSB +: 8] = REV_MAJOR;
                rd_data[MINOR_LSB +: 8] = REV_MINOR;
            end
            REG_CHIP_ID: begin
                rd_data[15:0] = CHIP_ID;
            end
            REG_PLL_CTRL: begin
                rd_data[SEC_STBY_POS]   = st_ff.pll_sb[1];
                rd_data[FIRST_STBY_POS] = st_ff.pll_sb[0];
                rd_data[SEC_BYP_POS]    = st_ff.pll_bp[1];
                rd_data[FIRST_BYP_POS]  = st_ff.pll_bp[0];
            end
            REG_RST_CFG: begin
                rd_data[VARIANT_POS] = st_ff.variant_sel;
            end
            REG_RST_STAT: begin
                rd_data[ST_POR_OUT_POS] = ~st_ff.por_out_n;
                rd_data[ST_MAN_OUT_POS] = ~st_ff.man_out_n;
                rd_data[ST_POR_IN_POS]  = ~st_ff.sy2[0];
                rd_data[ST_MAN_IN_POS]  = ~st_ff.sy2[1];
            end
            default: begin
                rd_ok = 1'b0;
            end
        endcase
    end

    always_comb begin
        nxt_st          = st_ff;
        nxt_st.sy1      = {FRONT_END_CLOCK_IN, MANUAL_RESET_IN_N, POWER_ON_RESET_IN_N};
        nxt_st.sy2      = st_ff.sy1;
        nxt_st.afe_prev = st_ff.sy2[2];
        // only bus writes touch the register file, never the manual reset
        if (wr_en && wr_strb[0]) begin
            if (wr_addr == REG_PLL_CTRL) begin
                nxt_st.pll_sb = {wr_data[SEC_STBY_POS], wr_data[FIRST_STBY_POS]};
                nxt_st.pll_bp = {wr_data[SEC_BYP_POS], wr_data[FIRST_BYP_POS]};
            end
            if (wr_addr == REG_RST_CFG) begin
                nxt_st.variant_sel = wr_data[VARIANT_POS];
            end
        end
        unique case (st_ff.man_st)
            MS_IDLE: begin
                if (!st_ff.sy2[1]) begin
                    nxt_st.man_var = st_ff.variant_sel;
                    nxt_st.seq_cnt = '0;
                    nxt_st.man_st  = st_ff.variant_sel ? MS_LEAD : MS_HOLD;
                end
            end
            MS_LEAD: begin
                nxt_st.seq_cnt = st_ff.seq_cnt + 1'b1;
                if (st_ff.seq_cnt == SEQ_W'(LEAD_CYC - 1)) begin
                    nxt_st.man_st = MS_HOLD;
                end
            end
            MS_HOLD: begin
                if (man_done && st_ff.sy2[1]) begin
                    nxt_st.seq_cnt = '0;
                    nxt_st.man_st  = st_ff.man_var ? MS_LAG : MS_IDLE;
                end
            end
            MS_LAG: begin
                nxt_st.seq_cnt = st_ff.seq_cnt + 1'b1;
                if (st_ff.seq_cnt == SEQ_W'(LAG_CYC - 1)) begin
                    nxt_st.man_st = MS_IDLE;
                end
            end
        endcase
        nxt_st.man_out_n = (nxt_st.man_st == MS_IDLE);
        // first variant adds power-on output inside the lead/lag window
        nxt_st.por_out_n = ~((st_ff.sy2[0] ? ~por_done : 1'b1) |
                             (nxt_st.man_st == MS_HOLD && nxt_st.man_var));
    end

    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            st_ff <= '{sy1: 3'h3, sy2: 3'h3, afe_prev: 1'b0,
                       pll_sb: PLL_STBY_RST, pll_bp: PLL_BYP_RST,
                       variant_sel: VARIANT_RST, man_st: MS_IDLE, man_var: 1'b0,
                       seq_cnt: '0, por_out_n: 1'b0, man_out_n: 1'b1};
        end else if (CE) begin
            st_ff <= nxt_st;
        end
    end

    assign POWER_ON_RESET_OUT_N = st_ff.por_out_n;
    assign MANUAL_RESET_OUT_N   = st_ff.man_out_n;
    assign SECOND_PLL_STANDBY   = st_ff.pll_sb[1];
    assign FIRST_PLL_STANDBY    = st_ff.pll_sb[0];
    assign SECOND_PLL_BYPASS    = st_ff.pll_bp[1];
    assign FIRST_PLL_BYPASS     = st_ff.pll_bp[0];

    a_pll_standby_write: assert property (@(posedge MCLK) disable iff (!RESET_N)
        (wr_en && wr_strb[0] && wr_addr == REG_PLL_CTRL) |=>
        (SECOND_PLL_STANDBY == $past(wr_data[5]) && FIRST_PLL_STANDBY == $past(wr_data[4])))
        else $error("pll standby bits not taken from write");

    a_pll_bypass_write: assert property (@(posedge MCLK) disable iff (!RESET_N)
        (wr_en && wr_strb[0] && wr_addr == REG_PLL_CTRL) |=>
        (SECOND_PLL_BYPASS == $past(wr_data[1]) && FIRST_PLL_BYPASS == $past(wr_data[0])))
        else $error("pll bypass bits not taken from write");

    a_revision_read: assert property (@(posedge MCLK) disable iff (!RESET_N)
        (ARVALID && ARREADY && ARADDR == REG_REVISION) |=>
        (RVALID && RRESP == RESP_OKAY && RDATA == {16'h0000, REV_MAJOR, REV_MINOR}))
        else $error("revision read returned wrong value");

    a_chip_id_read: assert property (@(posedge MCLK) disable iff (!RESET_N)
        (ARVALID && ARREADY && ARADDR == REG_CHIP_ID) |=>
        (RVALID && RDATA == {16'h0000, CHIP_ID}))
        else $error("chip identity read returned wrong value");

    a_por_in_held: assert property (@(posedge MCLK) disable iff (!RESET_N)
        (CE && !st_ff.sy2[0]) |=> !POWER_ON_RESET_OUT_N)
        else $error("power-on output released while input asserted");

    a_por_release_time: assert property (@(posedge MCLK) disable iff (!RESET_N)
        $rose(POWER_ON_RESET_OUT_N) |-> ($past(por_done) && $past(st_ff.sy2[0])))
        else $error("power-on output released before its period ended");

    a_man_second_hold: assert property (@(posedge MCLK) disable iff (!RESET_N)
        (CE && st_ff.man_st == MS_IDLE && !st_ff.sy2[1] && !st_ff.variant_sel) |=>
        (!MANUAL_RESET_OUT_N && st_ff.man_st == MS_HOLD))
        else $error("manual output not asserted for second variant");

    a_man_first_lead: assert property (@(posedge MCLK) disable iff (!RESET_N)
        (CE && st_ff.man_st == MS_IDLE && !st_ff.sy2[1] && st_ff.variant_sel) |=>
        (!MANUAL_RESET_OUT_N && st_ff.man_st == MS_LEAD) [*2] ##1
        (st_ff.man_st == MS_HOLD && !POWER_ON_RESET_OUT_N))
        else $error("first variant lead interval wrong");

    a_man_no_reinit: assert property (@(posedge MCLK) disable iff (!RESET_N)
        (CE && !st_ff.sy2[1] && !wr_en) |=>
        ($stable(st_ff.pll_sb) && $stable(st_ff.pll_bp) && $stable(st_ff.variant_sel)))
        else $error("manual reset changed a register");

    a_man_hold_input: assert property (@(posedge MCLK) disable iff (!RESET_N)
        (CE && st_ff.man_st == MS_HOLD && !st_ff.sy2[1]) |=>
        (!MANUAL_RESET_OUT_N && st_ff.man_st == MS_HOLD))
        else $error("manual output released while input asserted");

    a_por_idle_release: assert property (@(posedge MCLK) disable iff (!RESET_N)
        (CE && st_ff.sy2[0] && por_done && st_ff.man_st == MS_IDLE) |=> POWER_ON_RESET_OUT_N)
        else $error("power-on output held after its period ended");

    a_id_write_ignored: assert property (@(posedge MCLK) disable iff (!RESET_N)
        (wr_en && (wr_addr == REG_REVISION || wr_addr == REG_CHIP_ID)) |=>
        ($stable(st_ff.pll_sb) && $stable(st_ff.pll_bp) && $stable(st_ff.variant_sel)))
        else $error("write to read-only register changed state");

    a_pll_write_answer: assert property (@(posedge MCLK) disable iff (!RESET_N)
        (wr_en && wr_addr == REG_PLL_CTRL) |=>
        (BVALID && BRESP == RESP_OKAY))
        else $error("pll control write not answered okay");
endmodule

// file: dv/sprc_cpu_model.sv
`timescale 1ns/100ps
module sprc_cpu_model #(
    parameter int FE_HALF = 200
) (
    // reset pins seen by the cpu
    input  wire logic por_out_n,
    input  wire logic man_out_n,
    // front-end clock and event counts
    output logic      fe_clk,
    output int        boots,
    output int        warm
);
    // free-running, phase unrelated to the system clock
    initial begin
        fe_clk = 1'b0;
        #7;
        forever #(FE_HALF) fe_clk = ~fe_clk;
    end

    initial begin
        boots = 0;
        warm = 0;
    end

    // count cpu cold and warm restarts
    always @(posedge por_out_n) boots = boots + 1;
    always @(negedge man_out_n) @(posedge man_out_n) warm = warm + 1;
endmodule

// file: dv/system_pll_reset_control_tb.sv
`timescale 1ns/100ps
module system_pll_reset_control_tb;
    import sprc_pkg::*;
    localparam int          TK  = 8;
    localparam int          FE  = 10;
    localparam logic [7:0]  MAJ = 8'h07;    // arbitrary
    localparam logic [7:0]  MIN = 8'h04;    // arbitrary
    localparam logic [15:0] CID = 16'hC3A5; // arbitrary
    logic        mclk, reset_n, ce;
    logic [31:0] awaddr, wdata, araddr, rdata, rd, d;
    logic [3:0]  wstrb;
    logic        awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, rs;
    logic        por_in_n, man_in_n, fe_clk, por_out_n, man_out_n;
    logic        pll1_sb, pll2_sb, pll1_bp, pll2_bp;
    int          boots, warm, miscompares, comparisons, seed, i, n;
    int          mf, pf, mr, pr;

    sprc_top #(.POR_TICKS(TK), .MAN_TICKS(TK), .REV_MAJOR(MAJ), .REV_MINOR(MIN),
               .CHIP_ID(CID)) u_sprc_top (
        .MCLK(mclk), .RESET_N(reset_n), .CE(ce),
        .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
        .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
        .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
        .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
        .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
        .POWER_ON_RESET_IN_N(por_in_n), .MANUAL_RESET_IN_N(man_in_n),
        .FRONT_END_CLOCK_IN(fe_clk), .POWER_ON_RESET_OUT_N(por_out_n),
        .MANUAL_RESET_OUT_N(man_out_n), .FIRST_PLL_STANDBY(pll1_sb),
        .SECOND_PLL_STANDBY(pll2_sb), .FIRST_PLL_BYPASS(pll1_bp),
        .SECOND_PLL_BYPASS(pll2_bp));

    sprc_cpu_model #(.FE_HALF(FE * 20)) u_sprc_cpu_model (
        .por_out_n(por_out_n), .man_out_n(man_out_n), .fe_clk(fe_clk),
        .boots(boots), .warm(warm));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // writable pll bits only
    function automatic logic [31:0] pll_exp(input logic [31:0] v);
        return v & 32'h0000_0033;
    endfunction

    task automatic axw(input logic [31:0] a, input logic [31:0] dd);
        bit aw, w;
        aw = 0;
        w = 0;
        @(posedge mclk);
        awaddr <= a;
        wdata <= dd;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw && w)) begin
            @(posedge mclk);
            aw = aw | awready;
            w = w | wready;
            awvalid <= !aw;
            wvalid <= !w;
        end
        while (bvalid !== 1'b1) @(posedge mclk);
        rs = bresp;
        bready <= 1'b0;
    endtask

    task automatic axr(input logic [31:0] a);
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge mclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge mclk);
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask

    // pulse one reset pin, note the cycles at which the outputs move
    task automatic rst_run(input bit man);
        int k;
        mf = -1;
        pf = -1;
        mr = -1;
        pr = -1;
        @(posedge mclk);
        if (man) man_in_n <= 1'b0;
        else por_in_n <= 1'b0;
        for (k = 0; k < 30; k++) begin
            @(posedge mclk);
            if (mf < 0 && man_out_n === 1'b0) mf = k;
            if (pf < 0 && por_out_n === 1'b0) pf = k;
        end
        man_in_n <= 1'b1;
        por_in_n <= 1'b1;
        repeat ((TK - 1) * FE) @(posedge mclk);
        chk(man ? man_out_n : por_out_n, 1'b0);
        for (k = 0; k < 30; k++) begin
            @(posedge mclk);
            if (mr < 0 && man_out_n === 1'b1) mr = k;
            if (pr < 0 && por_out_n === 1'b1) pr = k;
        end
    endtask

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    initial begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        complete_run();
    end

    initial begin
        seed = 32'hfb63;
        miscompares = 0;
        comparisons = 0;
        {reset_n, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, wdata, araddr} = '0;
        wstrb = 4'hF;
        ce = 1'b1;
        por_in_n = 1'b1;
        man_in_n = 1'b1;
        repeat (12) @(posedge mclk);
        reset_n <= 1'b1;
        axr(REG_PLL_CTRL);
        chk(rd, 32'h0000_0000);
        axr(REG_REVISION);
        chk(rd, {16'h0000, MAJ, MIN});
        axw(REG_REVISION, 32'hFFFF_FFFF);
        axr(REG_REVISION);
        chk(rd, {16'h0000, MAJ, MIN});
        axw(REG_CHIP_ID, 32'h0000_0000);
        axr(REG_CHIP_ID);
        chk(rd, {16'h0000, CID});
        axr(32'h1000_0020);
        chk(rs, RESP_SLVERR);
        chk(rd, 32'h0000_0000);
        // enable low drops every ready
        ce <= 1'b0;
        repeat (3) @(posedge mclk);
        chk({awready, wready, arready}, 3'h0);
        ce <= 1'b1;
        n = 0;
        while (por_out_n !== 1'b1 && n < 300) begin
            @(posedge mclk);
            n++;
        end
        chk(por_out_n, 1'b1);
        // corner values first, then random
        for (i = 0; i < 8; i++) begin
            d = (i == 0) ? 32'hFFFF_FFFF : (i == 1) ? 32'h0000_0000 : $random(seed);
            axw(REG_PLL_CTRL, d);
            chk(rs, RESP_OKAY);
            chk({pll2_sb, pll1_sb, pll2_bp, pll1_bp}, {d[5], d[4], d[1], d[0]});
            axr(REG_PLL_CTRL);
            chk(rd, pll_exp(d));
        end
        rst_run(1'b0);
        chk({pf >= 0, pr >= 0, mf[29:0]}, {2'h3, 30'h3FFF_FFFF});
        chk(boots, 2);
        rst_run(1'b1);
        chk({mf >= 0, mr >= 0, pf[29:0]}, {2'h3, 30'h3FFF_FFFF});
        chk(warm, 1);
        axr(REG_PLL_CTRL);
        chk(rd, pll_exp(d));
        axw(REG_RST_CFG, 32'h0000_0001);
        rst_run(1'b1);
        chk(pf - mf, LEAD_CYC);
        chk(mr - pr, LAG_CYC);
        chk({mr >= 0, pr >= 0}, 2'h3);
        axr(REG_PLL_CTRL);
        chk(rd, pll_exp(d));
        complete_run();
    end
endmodule
